// *** hdl/display_diag_and_palette.sv ***
// APB register bank: display timing readback views and colour palette
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "display_diag_defs.svh"
module display_diag_and_palette #(
  parameter int ENTRIES = `LUT_ENTRIES
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal timing state from the display controller
  input wire logic [10:0] horiz_count_view,
  input wire logic [10:0] horiz_window_last,
  input wire logic [5:0] horiz_cursor_last,
  input wire logic [9:0] vert_count_view,
  input wire logic [9:0] vert_window_last,
  input wire logic [5:0] vert_cursor_last,
  input wire logic [18:0] window_line_base,
  input wire logic [11:0] window_line_bytes,
  input wire logic [18:0] cursor_line_base,
  input wire logic [13:0] compare_flags,
  // Refresh side
  input wire logic [7:0] pixel_index,
  input wire logic mono_mode,
  output logic [17:0] pixel_color,
  output logic [7:0] pixel_mono,
  // Test mode strobe
  output logic test_write_pulse
);

  display_diag_pkg::apb_state_t state;
  display_diag_pkg::apb_state_t next_state;
  display_diag_pkg::lut_word_t lut [ENTRIES];
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_test_write_pulse;
  logic [17:0] next_pixel_color;
  logic [7:0] next_pixel_mono;
  logic setup;
  logic lut_hit;
  logic [7:0] lut_idx;
  logic lut_we;

  function automatic logic [31:0] pack_entry(input logic [17:0] e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`RED_LSB +: 6] = e[5:0];
    w[`GREEN_LSB +: 6] = e[11:6];
    w[`BLUE_LSB +: 6] = e[17:12];
    return w;
  endfunction : pack_entry

  // True for the five readback offsets; shared by decode checks
  function automatic logic view_hit(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `OFS_COMPARE_FLAGS, `OFS_HORIZ_TIMING, `OFS_VERT_TIMING,
      `OFS_WINDOW_LINE, `OFS_CURSOR_LINE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : view_hit

  assign setup = psel && !penable;
  assign lut_hit = (paddr >= `OFS_LUT_FIRST) && (paddr <= `OFS_LUT_LAST);
  assign lut_idx = paddr[9:2];
  // Write commits at the completing edge, when the transfer is final
  assign lut_we = psel && penable && pready && pwrite && lut_hit;
  // Access phase is always one cycle: pready is high in it
  assign pready = (state == display_diag_pkg::ST_ACCESS);

  // Views are sampled once at setup; a fast counter may tear between
  // two register reads, which software has to tolerate
  always_comb begin
    next_state = state;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_test_write_pulse = 1'b0;
    case (state)
      display_diag_pkg::ST_IDLE: begin
        if (setup) begin
          next_state = display_diag_pkg::ST_ACCESS;
          next_prdata = 32'h0000_0000;
          if (lut_hit) begin
            if (!pwrite) begin
              next_prdata = pack_entry(lut[lut_idx]);
            end
          end else begin
            case (paddr)
              `OFS_COMPARE_FLAGS: next_prdata = {18'h0, compare_flags};
              `OFS_HORIZ_TIMING: next_prdata = {2'h0, horiz_cursor_last,
                1'b0, horiz_window_last, 1'b0, horiz_count_view};
              `OFS_VERT_TIMING: next_prdata = {2'h0, vert_cursor_last,
                2'h0, vert_window_last, 2'h0, vert_count_view};
              `OFS_WINDOW_LINE: next_prdata = {3'h0, window_line_bytes[11:3],
                1'b0, window_line_base};
              `OFS_CURSOR_LINE: begin
                next_prdata = {13'h0, cursor_line_base[18:4], 4'h0};
                next_test_write_pulse = pwrite;
              end
              default: next_pslverr = 1'b1;
            endcase
            // Readback views never store write data; a cursor line write still pulses test_write_pulse
            if (pwrite) begin
              next_prdata = 32'h0000_0000;
            end
          end
        end
      end
      display_diag_pkg::ST_ACCESS: begin
        next_state = display_diag_pkg::ST_IDLE;
      end
      default: next_state = display_diag_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= display_diag_pkg::ST_IDLE;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      test_write_pulse <= 1'b0;
    end else begin
      state <= next_state;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      test_write_pulse <= next_test_write_pulse;
    end
  end

  // Bus timing and readback views
  a_ready_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("pready did not follow setup by one cycle");
  a_horiz_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `OFS_HORIZ_TIMING |=>
    prdata[10:0] == $past(horiz_count_view) && !prdata[11])
    else $error("horizontal counter view wrong");
  a_horiz_window: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `OFS_HORIZ_TIMING |=>
    prdata[22:12] == $past(horiz_window_last) && !prdata[23] &&
    prdata[29:24] == $past(horiz_cursor_last) && prdata[31:30] == 2'h0)
    else $error("horizontal end positions wrong");
  a_vert_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `OFS_VERT_TIMING |=>
    prdata[9:0] == $past(vert_count_view) && prdata[11:10] == 2'h0)
    else $error("vertical counter view wrong");
  a_vert_ends: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `OFS_VERT_TIMING |=>
    prdata[21:12] == $past(vert_window_last) && prdata[23:22] == 2'h0 &&
    prdata[29:24] == $past(vert_cursor_last) && prdata[31:30] == 2'h0)
    else $error("vertical end positions wrong");
  a_window_line: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `OFS_WINDOW_LINE |=>
    prdata[18:0] == $past(window_line_base) && !prdata[19])
    else $error("window line start view wrong");
  a_window_bytes: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `OFS_WINDOW_LINE |=>
    prdata[28:20] == $past(window_line_bytes[11:3]) &&
    prdata[31:29] == 3'h0)
    else $error("window byte count view wrong");
  a_cursor_line: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `OFS_CURSOR_LINE |=>
    prdata == {13'h0, $past(cursor_line_base[18:4]), 4'h0})
    else $error("cursor line readback wrong");
  a_test_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    test_write_pulse |-> $past(setup && pwrite &&
    paddr == `OFS_CURSOR_LINE) ##1 !test_write_pulse)
    else $error("test pulse without cursor line write");
  a_pulse_on_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && pwrite && paddr == `OFS_CURSOR_LINE |=> test_write_pulse)
    else $error("cursor line write gave no test pulse");
  a_read_no_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite |=> !test_write_pulse)
    else $error("test pulse on a read");
  a_view_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && pwrite && view_hit(paddr) |=>
    prdata == 32'h0000_0000 && !pslverr)
    else $error("write to a readback view not ignored");
  a_diag_no_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && view_hit(paddr) |=> !pslverr)
    else $error("readback view access flagged as error");
  a_flags_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == `OFS_COMPARE_FLAGS |=>
    prdata == {18'h0, $past(compare_flags)})
    else $error("compare flags readback wrong");
  a_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !lut_hit && !view_hit(paddr) |=>
    pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  a_prdata_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !setup |=> $stable(prdata))
    else $error("read data changed without a setup");
  a_error_in_access: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && !test_write_pulse)
    else $error("error response outside access phase");

  // Table has no reset: contents stay undefined until written
  always_ff @(posedge pclk) begin
    if (lut_we) begin
      lut[lut_idx] <= {pwdata[`BLUE_LSB +: 6], pwdata[`GREEN_LSB +: 6],
        pwdata[`RED_LSB +: 6]};
    end
  end

  // Palette access through the bus
  a_lut_roundtrip: assert property (
    @(posedge pclk) disable iff (!presetn)
    lut_we ##1 (setup && !pwrite && paddr == $past(paddr)) |=>
    prdata == ($past(pwdata, 2) & `LUT_FIELD_MASK))
    else $error("palette read after write mismatch");
  a_lut_reserved: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && lut_hit |=> (prdata & ~`LUT_FIELD_MASK) == 32'h0)
    else $error("palette reserved bits not zero");
  a_lut_no_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && lut_hit |=> !pslverr && !test_write_pulse)
    else $error("palette access flagged as error");

  always_comb begin
    // Registered lookup: colour lags the index by one cycle
    next_pixel_color = lut[pixel_index];
    // Mono tone: blue gives the low six bits, top green bits the rest
    next_pixel_mono = {next_pixel_color[11:10], next_pixel_color[17:12]};
    if (!mono_mode) begin
      next_pixel_mono = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_color <= 18'h00000;
      pixel_mono <= 8'h00;
    end else begin
      pixel_color <= next_pixel_color;
      pixel_mono <= next_pixel_mono;
    end
  end

  // Refresh side mono mapping
  a_mono_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    mono_mode |=> pixel_mono == {pixel_color[11:10], pixel_color[17:12]})
    else $error("mono palette mapping wrong");
  a_mono_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mono_mode |=> pixel_mono == 8'h00)
    else $error("mono output active outside mono mode");

  // Main scenarios that the bench should reach
  c_lut_write: cover property (@(posedge pclk) disable iff (!presetn) lut_we);
  c_lut_read: cover property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && lut_hit);
  c_test_pulse: cover property (@(posedge pclk) disable iff (!presetn)
    test_write_pulse);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr && pready);
  c_mono_pixel: cover property (@(posedge pclk) disable iff (!presetn)
    mono_mode ##1 pixel_mono != 8'h00);

endmodule : display_diag_and_palette

// *** hdl/display_diag_defs.svh ***
// Offsets, field positions and sizes for the diagnostic and palette block
`ifndef DISPLAY_DIAG_DEFS_SVH
`define DISPLAY_DIAG_DEFS_SVH
`define OFS_COMPARE_FLAGS 12'h1EC
`define OFS_HORIZ_TIMING 12'h1F0
`define OFS_VERT_TIMING 12'h1F4
`define OFS_WINDOW_LINE 12'h1F8
`define OFS_CURSOR_LINE 12'h1FC
`define OFS_LUT_FIRST 12'h800
`define OFS_LUT_LAST 12'hBFC
`define LUT_ENTRIES 256
`define LUT_WIDTH 18
`define RED_LSB 2
`define GREEN_LSB 10
`define BLUE_LSB 18
`define LUT_FIELD_MASK 32'h00FC_FCFC
`endif

// *** hdl/display_diag_pkg.sv ***
// Types shared by the diagnostic and palette block
package display_diag_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } apb_state_t;
  typedef logic [17:0] lut_word_t;
endpackage : display_diag_pkg

// *** test/display_diag_and_palette_bench.sv ***
// Self-checking bench for the timing readback and palette register block
`timescale 1ns/100ps
module display_diag_and_palette_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic mono_mode = 1'b0;
  logic pcheck = 1'b0;
  logic pchk_d = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, d;
  logic pready, pslverr, test_write_pulse;
  logic [10:0] hcv = 11'h0, hwl = 11'h0;
  logic [9:0] vcv = 10'h0, vwl = 10'h0;
  logic [5:0] hcl = 6'h0, vcl = 6'h0;
  logic [18:0] wlb = 19'h0, clb = 19'h0;
  logic [11:0] wbytes = 12'h0;
  logic [13:0] flags = 14'h0;
  logic [7:0] pixel_index = 8'h00, pixel_mono;
  logic [17:0] pixel_color;
  logic [7:0] ix [16];
  logic [11:0] dar [5] = '{12'h1EC, 12'h1F0, 12'h1F4, 12'h1F8, 12'h1FC};
  logic [11:0] bad [4] = '{12'h1E8, 12'h7FC, 12'hC00, 12'h000};
  logic [31:0] lut [256];
  logic [33:0] bq [$];
  logic [25:0] pq [$];
  logic [33:0] e;
  logic [25:0] pe;
  int mismatches = 0, total_checks = 0, cycles = 0, seed = 32'h102e;

  display_diag_and_palette display_diag_and_palette_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .horiz_count_view(hcv),
    .horiz_window_last(hwl), .horiz_cursor_last(hcl),
    .vert_count_view(vcv), .vert_window_last(vwl), .vert_cursor_last(vcl),
    .window_line_base(wlb), .window_line_bytes(wbytes),
    .cursor_line_base(clb), .compare_flags(flags),
    .pixel_index(pixel_index), .mono_mode(mono_mode),
    .pixel_color(pixel_color), .pixel_mono(pixel_mono),
    .test_write_pulse(test_write_pulse));

  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Entered just after an edge; leaves the bus held so the next can follow
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, input logic [33:0] x);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    bq.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
  endtask : apb

  task automatic pix(input logic [7:0] i, input logic m);
    @(posedge pclk);
    pixel_index <= i;
    mono_mode <= m;
    pcheck <= 1'b1;
    pq.push_back({m ? {lut[i][15:14], lut[i][23:18]} : 8'h00,
                  lut[i][23:18], lut[i][15:10], lut[i][7:2]});
    @(posedge pclk);
    pcheck <= 1'b0;
  endtask : pix

  function automatic logic [31:0] dexp(input logic [11:0] a);
    case (a)
      12'h1F0: return {2'h0, hcl, 1'b0, hwl, 1'b0, hcv};
      12'h1F4: return {2'h0, vcl, 2'h0, vwl, 2'h0, vcv};
      12'h1F8: return {3'h0, wbytes[11:3], 1'b0, wlb};
      12'h1FC: return {13'h0, clb[18:4], 4'h0};
      default: return {18'h0, flags};
    endcase
  endfunction : dexp

  // Results are matched against the oldest note as they appear
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    pchk_d <= pcheck;
    if (psel && penable && pready === 1'b1) begin
      e = bq.pop_front();
      check(pslverr, e[32]);
      if (!e[33]) check(prdata, e[31:0]);
      check(test_write_pulse, pwrite && paddr == 12'h1FC);
    end
    if (pchk_d) begin
      pe = pq.pop_front();
      check(pixel_color, pe[17:0]);
      check(pixel_mono, pe[25:18]);
    end
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    @(posedge pclk);
    check(pready, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    // Odd rounds also write every view, which must not disturb it
    for (int k = 0; k < 6; k++) begin
      {hcv, hwl, hcl, vcv, vwl, vcl} <= 54'({$random(seed), $random(seed)});
      {wlb, clb, wbytes, flags} <= {$random(seed), $random(seed)};
      @(posedge pclk);
      foreach (dar[j]) begin
        if (k[0]) apb(1'b1, dar[j], $random(seed), {2'b10, 32'h0});
        apb(1'b0, dar[j], 32'h0,
            {2'b00, dexp(dar[j])});
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
    $display("timing readback test done");
    @(posedge pclk);
    for (int j = 0; j < 16; j++) begin
      ix[j] = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : 8'($random(seed));
      d = $random(seed);
      lut[ix[j]] = d & 32'h00FCFCFC;
      apb(1'b1, 12'h800 | {2'b00, ix[j], 2'b00}, d, {2'b10, 32'h0});
      apb(1'b0, 12'h800 | {2'b00, ix[j], 2'b00}, 32'h0,
          {2'b00, lut[ix[j]]});
    end
    foreach (ix[j]) apb(1'b0, 12'h800 | {2'b00, ix[j], 2'b00}, 32'h0,
                        {2'b00, lut[ix[j]]});
    psel <= 1'b0;
    penable <= 1'b0;
    foreach (ix[j]) pix(ix[j], j[0]);
    $display("palette test done");
    @(posedge pclk);
    foreach (bad[j]) apb(1'b0, bad[j], 32'h0, {2'b01, 32'h0});
    foreach (bad[j]) apb(1'b1, bad[j], $random(seed), {2'b11, 32'h0});
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
    check(bq.size() + pq.size(), 32'h0);
    $display("unmapped access test done");
    conclude();
  end
endmodule : display_diag_and_palette_bench
